// ---- hw/ccpm_ptimer.v ----
// Period timer: prescaler, 8-bit counter with period match, postscaler
`include "ccpm_regs.vh"
module ccpm_ptimer #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rstn,
  // Configuration
  input  wire         run,
  input  wire [1:0]   pre_sel,
  input  wire [3:0]   post_sel,
  input  wire [W-1:0] limit,
  // Software access
  input  wire         cnt_wr,
  input  wire [W-1:0] cnt_wdata,
  input  wire         scal_clr,
  // Results
  output reg  [W-1:0] count_q,
  output wire [1:0]   fine,
  output wire         match,
  output wire         post_pulse
);
  reg  [3:0] pre_q;   // Prescaler counter
  reg  [3:0] post_q;  // Postscaler counter
  wire [3:0] pre_max; // Terminal prescaler count
  wire       tick;    // One increment cycle

  // Prescaler terminal count from the select code
  assign pre_max = (pre_sel == `CCPM_PS_DIV1) ? `CCPM_PRE_DIV1 :
                   (pre_sel == `CCPM_PS_DIV4) ? `CCPM_PRE_DIV4 :
                   `CCPM_PRE_DIV16;
  assign tick = run & (pre_q == pre_max);
  assign match = tick & (count_q == limit);
  assign post_pulse = match & (post_q == post_sel);
  // Sub-cycle phase for the PWM low duty bits
  assign fine = (pre_sel == `CCPM_PS_DIV1) ? 2'h0 :
                (pre_sel == `CCPM_PS_DIV4) ? pre_q[1:0] : pre_q[3:2];

  // Prescaler and postscaler, cleared by count or control writes
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_q  <= 4'h0;
      post_q <= 4'h0;
    end
    else if (cnt_wr | scal_clr)
    begin
      pre_q  <= 4'h0;
      post_q <= 4'h0;
    end
    else
    begin
      if (run)
        pre_q <= tick ? 4'h0 : pre_q + 4'h1;
      if (match)
        post_q <= post_pulse ? 4'h0 : post_q + 4'h1;
    end
  end

  // Counter; a software write wins over an increment
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      count_q <= {W{1'b0}};
    else if (cnt_wr)
      count_q <= cnt_wdata;
    else if (match)
      count_q <= {W{1'b0}};
    else if (tick)
      count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
  end
endmodule // ccpm_ptimer

// ---- hw/ccpm_regs.vh ----
// Register map, field positions, reset values and mode codes
`ifndef CCPM_REGS_VH
`define CCPM_REGS_VH
// Byte addresses on the register bus
`define CCPM_A_COUNT   8'h00
`define CCPM_A_LIMIT   8'h04
`define CCPM_A_CTRL    8'h08
`define CCPM_A_FLAGS   8'h0c
`define CCPM_A_ROUTE   8'h10
`define CCPM_A_WDOG    8'h14
`define CCPM_A_SHARED  8'h18
`define CCPM_A_U4_CTRL 8'h20
`define CCPM_A_U4_LOW  8'h24
`define CCPM_A_U4_HIGH 8'h28
`define CCPM_A_U5_CTRL 8'h30
`define CCPM_A_U5_LOW  8'h34
`define CCPM_A_U5_HIGH 8'h38
// Period timer control fields
`define CCPM_CTRL_RUN   2
`define CCPM_CTRL_PS_HI 1
`define CCPM_CTRL_PS_LO 0
`define CCPM_CTRL_PO_HI 6
`define CCPM_CTRL_PO_LO 3
// Flag bits
`define CCPM_FLAG_MATCH 0
`define CCPM_FLAG_U4    1
`define CCPM_FLAG_U5    2
// Watchdog control alternate select bit
`define CCPM_WDOG_ALT   4
// Reset values
`define CCPM_LIMIT_RST  8'hff
`define CCPM_ZERO8      8'h00
// Prescaler terminal counts
`define CCPM_PRE_DIV1   4'h0
`define CCPM_PRE_DIV4   4'h3
`define CCPM_PRE_DIV16  4'hf
`define CCPM_PS_DIV1    2'h0
`define CCPM_PS_DIV4    2'h1
// Unit mode codes
`define CCPM_M_OFF      4'h0
`define CCPM_M_TOGGLE   4'h2
`define CCPM_M_CAP_FALL 4'h4
`define CCPM_M_CAP_RISE 4'h5
`define CCPM_M_CAP_4    4'h6
`define CCPM_M_CAP_16   4'h7
`define CCPM_M_CMP_HI   4'h8
`define CCPM_M_CMP_LO   4'h9
`define CCPM_M_CMP_SW   4'ha
`define CCPM_M_CMP_TRIG 4'hb
`define CCPM_CAP_N4     4'h3
`define CCPM_CAP_N16    4'hf
// Routing codes
`define CCPM_RT_ALL_LOW 2'h0
`define CCPM_RT_ONE     2'h1
`define CCPM_RT_TWO     2'h2
`endif

// ---- hw/ccpm_top.v ----
// Capture/compare/PWM mode select block with the period timer and APB slave
// What this block does
// - Prescaler divides instruction clock by 1, 4, 16
// - Postscaler 1..16 on matches sets match flag
// - Run bit starts and stops the period timer
// - Count or control write, reset clear scalers
// - Control write leaves the count untouched
// - Count register read/write, reset to zero
// - Count up to limit, then back to zero
// - Limit register read/write, reset value FFh
// - Unscaled match is only a PWM time base
// - PWM duty is ten bits, low byte high
// - Mode zero disables and resets unit state
// - Mode 0010 toggles pin, sets event flag
// - Modes 0100-0111 capture on selected pin edges
// - Modes 1000/1001 init pin low/high (low from mode zero), force on match
// - Mode 1010 flags only, pin shows port latch
// - Mode 1011 special trigger resets timer, starts conversion
// - Capture/compare use timer 1/3, PWM 2/4
// - Control, low and high registers readable writable
// - Routing 00: all units on first/second timers
// - Routing 01: only enhanced unit one on first pair
// - One setting: first two enhanced units on first pair
// - One setting: all units on third/fourth timers
// - Open-drain bit switches output-mode pin driver
// - Open-drain register overlays first timer high byte
// - Period restart sets pin unless duty is zero, latches duty to high
//
// Added by the designer: the APB register port and the register offsets.
`include "ccpm_regs.vh"
module ccpm_top (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // Outside timers
  input  wire [15:0] first_timer_count,
  input  wire [15:0] third_timer_count,
  input  wire [7:0]  second_timer_count,
  input  wire        second_timer_restart,
  // Special event outputs
  output wire        first_timer_reset,
  output wire        third_timer_reset,
  output wire        adc_start,
  // Period timer time base and routing view
  output wire        period_timer_base,
  output wire [4:0]  unit_uses_alt,
  // Unit pins, index 0 is unit four, index 1 is unit five
  input  wire [1:0]  unit_pin_in,
  input  wire [1:0]  unit_port_latch,
  output wire [1:0]  unit_pin_out,
  output wire [1:0]  unit_pin_oe_n
);
  // Software-visible state
  reg  [7:0]  limit_q;     // Period timer limit
  reg  [6:0]  ctrl_q;      // Period timer control
  reg  [2:0]  flag_q;      // Sticky event flags
  reg  [1:0]  route_q;     // Timer routing select
  reg         alt_q;       // Alternate register select
  reg  [4:0]  od_q;        // Open-drain control bits
  // Bus decode
  wire        wr_en;       // Write takes effect this edge
  wire        setup;       // Setup phase of a transfer
  reg  [31:0] rd_val;      // Read value for the held address
  reg         miss;        // Unmapped address
  // Period timer results
  wire [7:0]  pt_count;
  wire [1:0]  pt_fine;
  wire        pt_match;
  wire        pt_post;
  // Unit results
  wire [5:0]  u4_ctrl;
  wire [7:0]  u4_low;
  wire [7:0]  u4_high;
  wire        u4_event;
  wire        u4_trig;
  wire [5:0]  u5_ctrl;
  wire [7:0]  u5_low;
  wire [7:0]  u5_high;
  wire        u5_event;
  wire        u5_trig;
  // Write strobes
  wire        cnt_wr;
  wire        ctl_wr;
  wire        u4_ctrl_wr;
  wire        u4_low_wr;
  wire        u4_high_wr;
  wire        u5_ctrl_wr;
  wire        u5_low_wr;
  wire        u5_high_wr;
  reg  [4:0]  alt_sel;
  wire [2:0]  flag_set;
  wire [2:0]  flag_clr;

  // The slave answers with no wait states
  assign pready = 1'b1;
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite;

  // Write strobes from the held address
  assign cnt_wr     = wr_en & (paddr == `CCPM_A_COUNT);
  assign ctl_wr     = wr_en & (paddr == `CCPM_A_CTRL);
  assign u4_ctrl_wr = wr_en & (paddr == `CCPM_A_U4_CTRL);
  assign u4_low_wr  = wr_en & (paddr == `CCPM_A_U4_LOW);
  assign u4_high_wr = wr_en & (paddr == `CCPM_A_U4_HIGH);
  assign u5_ctrl_wr = wr_en & (paddr == `CCPM_A_U5_CTRL);
  assign u5_low_wr  = wr_en & (paddr == `CCPM_A_U5_LOW);
  assign u5_high_wr = wr_en & (paddr == `CCPM_A_U5_HIGH);

  // Routing: bit n is set when unit n+1 uses the third and fourth timers
  always @*
  begin
    if (route_q == `CCPM_RT_ALL_LOW)
      alt_sel = 5'h00;
    else if (route_q == `CCPM_RT_ONE)
      alt_sel = 5'h1e;
    else if (route_q == `CCPM_RT_TWO)
      alt_sel = 5'h1c;
    else
      alt_sel = 5'h1f;
  end
  assign unit_uses_alt = alt_sel;

  // Read decode; the watchdog word holds only the alternate select bit
  always @*
  begin
    rd_val = 32'h0000_0000;
    miss   = 1'b0;
    if (paddr == `CCPM_A_COUNT)
      rd_val[7:0] = pt_count;
    else if (paddr == `CCPM_A_LIMIT)
      rd_val[7:0] = limit_q;
    else if (paddr == `CCPM_A_CTRL)
      rd_val[6:0] = ctrl_q;
    else if (paddr == `CCPM_A_FLAGS)
      rd_val[2:0] = flag_q;
    else if (paddr == `CCPM_A_ROUTE)
      rd_val[1:0] = route_q;
    else if (paddr == `CCPM_A_WDOG)
      rd_val[`CCPM_WDOG_ALT] = alt_q;
    else if (paddr == `CCPM_A_SHARED)
    begin
      if (alt_q)
        rd_val[4:0] = od_q;
      else
        rd_val[7:0] = first_timer_count[15:8];
    end
    else if (paddr == `CCPM_A_U4_CTRL)
      rd_val[5:0] = u4_ctrl;
    else if (paddr == `CCPM_A_U4_LOW)
      rd_val[7:0] = u4_low;
    else if (paddr == `CCPM_A_U4_HIGH)
      rd_val[7:0] = u4_high;
    else if (paddr == `CCPM_A_U5_CTRL)
      rd_val[5:0] = u5_ctrl;
    else if (paddr == `CCPM_A_U5_LOW)
      rd_val[7:0] = u5_low;
    else if (paddr == `CCPM_A_U5_HIGH)
      rd_val[7:0] = u5_high;
    else
      miss = 1'b1;
  end

  // Read data and error are captured in the setup phase, so they come
  // from flops and are stable for the whole access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= miss;
    end
  end

  // Configuration registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      limit_q <= `CCPM_LIMIT_RST;
      ctrl_q  <= 7'h00;
      route_q <= `CCPM_RT_ALL_LOW;
      alt_q   <= 1'b0;
      od_q    <= 5'h00;
    end
    else if (wr_en)
    begin
      if (paddr == `CCPM_A_LIMIT)
        limit_q <= pwdata[7:0];
      else if (paddr == `CCPM_A_CTRL)
        ctrl_q <= pwdata[6:0];
      else if (paddr == `CCPM_A_ROUTE)
        route_q <= pwdata[1:0];
      else if (paddr == `CCPM_A_WDOG)
        alt_q <= pwdata[`CCPM_WDOG_ALT];
      else if ((paddr == `CCPM_A_SHARED) & alt_q)
        od_q <= pwdata[4:0];
    end
  end

  // Sticky flags, write one to clear; a set in the same cycle wins
  assign flag_set = {u5_event, u4_event, pt_post};
  assign flag_clr = (wr_en & (paddr == `CCPM_A_FLAGS)) ? pwdata[2:0] : 3'h0;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= 3'h0;
    else
      flag_q <= (flag_q & ~flag_clr) | flag_set;
  end

  // Period timer, the fourth timer
  ccpm_ptimer #(
    .W (8)
  ) u_ptimer (
    .clk        (pclk),
    .rstn       (presetn),
    .run        (ctrl_q[`CCPM_CTRL_RUN]),
    .pre_sel    (ctrl_q[`CCPM_CTRL_PS_HI:`CCPM_CTRL_PS_LO]),
    .post_sel   (ctrl_q[`CCPM_CTRL_PO_HI:`CCPM_CTRL_PO_LO]),
    .limit      (limit_q),
    .cnt_wr     (cnt_wr),
    .cnt_wdata  (pwdata[7:0]),
    .scal_clr   (ctl_wr),
    .count_q    (pt_count),
    .fine       (pt_fine),
    .match      (pt_match),
    .post_pulse (pt_post)
  );
  // The unscaled match leaves only as a PWM time base
  assign period_timer_base = pt_match;

  // Unit four
  ccpm_unit u_unit4 (
    .clk         (pclk),
    .rstn        (presetn),
    .ctrl_wr     (u4_ctrl_wr),
    .low_wr      (u4_low_wr),
    .high_wr     (u4_high_wr),
    .wdata       (pwdata[7:0]),
    .cc_count    (alt_sel[3] ? third_timer_count : first_timer_count),
    .pwm_count   (alt_sel[3] ? pt_count : second_timer_count),
    .pwm_fine    (alt_sel[3] ? pt_fine : 2'h0),
    .pwm_restart (alt_sel[3] ? pt_match : second_timer_restart),
    .pin_in      (unit_pin_in[0]),
    .port_latch  (unit_port_latch[0]),
    .open_drain  (od_q[3]),
    .ctrl_q      (u4_ctrl),
    .low_q       (u4_low),
    .high_q      (u4_high),
    .event_q     (u4_event),
    .trig_q      (u4_trig),
    .pin_out_q   (unit_pin_out[0]),
    .pin_oe_n_q  (unit_pin_oe_n[0])
  );

  // Unit five
  ccpm_unit u_unit5 (
    .clk         (pclk),
    .rstn        (presetn),
    .ctrl_wr     (u5_ctrl_wr),
    .low_wr      (u5_low_wr),
    .high_wr     (u5_high_wr),
    .wdata       (pwdata[7:0]),
    .cc_count    (alt_sel[4] ? third_timer_count : first_timer_count),
    .pwm_count   (alt_sel[4] ? pt_count : second_timer_count),
    .pwm_fine    (alt_sel[4] ? pt_fine : 2'h0),
    .pwm_restart (alt_sel[4] ? pt_match : second_timer_restart),
    .pin_in      (unit_pin_in[1]),
    .port_latch  (unit_port_latch[1]),
    .open_drain  (od_q[4]),
    .ctrl_q      (u5_ctrl),
    .low_q       (u5_low),
    .high_q      (u5_high),
    .event_q     (u5_event),
    .trig_q      (u5_trig),
    .pin_out_q   (unit_pin_out[1]),
    .pin_oe_n_q  (unit_pin_oe_n[1])
  );

  // Special event trigger resets whichever timer the unit uses
  assign first_timer_reset = (u4_trig & ~alt_sel[3]) | (u5_trig & ~alt_sel[4]);
  assign third_timer_reset = (u4_trig & alt_sel[3]) | (u5_trig & alt_sel[4]);
  assign adc_start         = u4_trig | u5_trig;
endmodule // ccpm_top

// ---- hw/ccpm_unit.v ----
// One capture/compare/PWM unit with its control and data registers
`include "ccpm_regs.vh"
module ccpm_unit (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Register writes
  input  wire        ctrl_wr,
  input  wire        low_wr,
  input  wire        high_wr,
  input  wire [7:0]  wdata,
  // Time bases
  input  wire [15:0] cc_count,
  input  wire [7:0]  pwm_count,
  input  wire [1:0]  pwm_fine,
  input  wire        pwm_restart,
  // Pin side
  input  wire        pin_in,
  input  wire        port_latch,
  input  wire        open_drain,
  // Register contents and events
  output reg  [5:0]  ctrl_q,
  output reg  [7:0]  low_q,
  output reg  [7:0]  high_q,
  output reg         event_q,
  output reg         trig_q,
  output reg         pin_out_q,
  output reg         pin_oe_n_q
);
  wire [3:0] mode   = ctrl_q[3:0];
  wire       is_cap = (mode[3:2] == 2'b01);
  wire       is_pwm = (mode[3:2] == 2'b11);
  wire       is_cmp = (mode == `CCPM_M_TOGGLE) | (mode[3:2] == 2'b10);
  reg        pin_q;   // Previous pin sample
  reg  [3:0] pre_q;   // Capture edge prescaler
  reg        eq_q;    // Previous compare equality
  reg        lat_q;   // Output latch
  reg  [1:0] dlat_q;  // Latched duty low bits
  wire       rise = pin_in & ~pin_q;
  wire       fall = ~pin_in & pin_q;
  wire       eq   = (cc_count == {high_q, low_q});
  wire       hit  = is_cmp & eq & ~eq_q;
  wire [9:0] duty = {low_q, ctrl_q[5:4]};
  reg        cap;
  reg        drive;

  // Capture event selection
  always @*
  begin
    cap = 1'b0;
    case (mode)
      `CCPM_M_CAP_FALL: cap = fall;
      `CCPM_M_CAP_RISE: cap = rise;
      `CCPM_M_CAP_4:    cap = rise & (pre_q[1:0] == `CCPM_CAP_N4);
      `CCPM_M_CAP_16:   cap = rise & (pre_q == `CCPM_CAP_N16);
      default:          cap = 1'b0;
    endcase
  end

  // Registers, capture, compare and PWM state
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= 6'h00;
      low_q  <= 8'h00;
      high_q <= 8'h00;
      pin_q  <= 1'b0;
      pre_q  <= 4'h0;
      eq_q   <= 1'b0;
      lat_q  <= 1'b0;
      dlat_q <= 2'h0;
      event_q <= 1'b0;
      trig_q <= 1'b0;
    end
    else
    begin
      pin_q   <= pin_in;
      eq_q    <= eq;
      event_q <= cap | hit;
      trig_q  <= hit & (mode == `CCPM_M_CMP_TRIG);
      // Edge prescaler only counts while capturing
      if (!is_cap)
        pre_q <= 4'h0;
      else if (rise)
        pre_q <= pre_q + 4'h1;
      if (ctrl_wr)
        ctrl_q <= wdata[5:0];
      // Software writes win over a capture in the same cycle
      if (low_wr)
        low_q <= wdata;
      else if (cap)
        low_q <= cc_count[7:0];
      if (high_wr)
        high_q <= wdata;
      else if (cap)
        high_q <= cc_count[15:8];
      else if (is_pwm & pwm_restart)
        high_q <= low_q;
      // Output latch
      if (mode == `CCPM_M_OFF)
      begin
        lat_q  <= 1'b0;
        dlat_q <= 2'h0;
      end
      else if (ctrl_wr & (wdata[3:0] == `CCPM_M_CMP_HI))
        lat_q <= 1'b0;
      else if (ctrl_wr & (wdata[3:0] == `CCPM_M_CMP_LO))
        lat_q <= 1'b1;
      else if (hit & (mode == `CCPM_M_TOGGLE))
        lat_q <= ~lat_q;
      else if (hit & (mode == `CCPM_M_CMP_HI))
        lat_q <= 1'b1;
      else if (hit & (mode == `CCPM_M_CMP_LO))
        lat_q <= 1'b0;
      else if (is_pwm & pwm_restart)
      begin
        lat_q  <= (duty != 10'h000);
        dlat_q <= ctrl_q[5:4];
      end
      else if (is_pwm & ({pwm_count, pwm_fine} == {high_q, dlat_q}))
        lat_q <= 1'b0;
    end
  end

  // Pin driver; software-interrupt mode shows the port latch
  always @*
  begin
    drive = (mode == `CCPM_M_CMP_SW) ? port_latch : lat_q;
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_out_q  <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end
    else if ((is_cmp | is_pwm) & open_drain)
    begin
      pin_out_q  <= 1'b0;
      pin_oe_n_q <= drive;
    end
    else if (is_cmp | is_pwm)
    begin
      pin_out_q  <= drive;
      pin_oe_n_q <= 1'b0;
    end
    else
    begin
      pin_out_q  <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end
  end
endmodule // ccpm_unit

// ---- tb/ccpm_pin_model.sv ----
// Outside world on the unit pins: drivers and pull-ups
module ccpm_pin_model (
  // Design side
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe_n,
  // Bench side
  input  wire logic [1:0] ext_val,
  input  wire logic [1:0] ext_en,
  // Resolved level
  output var  logic [1:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Design first, then outside driver, else the pull-up
  always_comb
    for (int i = 0; i < 2; i++)
      pin_lvl[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
endmodule // ccpm_pin_model

// ---- tb/ccpm_props.sv ----
// Checker for the mode select block, bound to its top
`include "ccpm_regs.vh"
module ccpm_props (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // Register bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pslverr,
  // Events, routing and pins
  input wire        first_timer_reset,
  input wire        third_timer_reset,
  input wire        adc_start,
  input wire [4:0]  unit_uses_alt,
  input wire [1:0]  unit_port_latch,
  input wire [1:0]  unit_pin_out,
  input wire [1:0]  unit_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] m4_q;   // Unit four mode as last written
  logic [1:0] rt_q;   // Routing code as last written
  logic [4:0] rt_exp; // Expected routing view
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadow the writes that steer pins and routing
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      m4_q <= 4'h0;
      rt_q <= 2'h0;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == `CCPM_A_U4_CTRL)
        m4_q <= pwdata[3:0];
      if (paddr == `CCPM_A_ROUTE)
        rt_q <= pwdata[1:0];
    end
  // Bit n set means unit n+1 is on the alternate pair
  always_comb
    case (rt_q)
      2'h0:    rt_exp = 5'h00;
      2'h1:    rt_exp = 5'h1e;
      2'h2:    rt_exp = 5'h1c;
      default: rt_exp = 5'h1f;
    endcase
  route_map_a: assert property (unit_uses_alt == rt_exp)
    else $error("routing view wrong");
  off_pin_a: assert property ((m4_q == `CCPM_M_OFF) [*2] |-> unit_pin_oe_n[0])
    else $error("disabled unit drives pin");
  sw_pin_a: assert property ((m4_q == `CCPM_M_CMP_SW) [*2] |->
    unit_pin_out[0] == $past(unit_port_latch[0]))
    else $error("pin not on port latch");
  trig_one_a: assert property (first_timer_reset |=> !first_timer_reset)
    else $error("timer reset too long");
  adc_pair_a: assert property (adc_start |-> (first_timer_reset || third_timer_reset))
    else $error("start without reset");
  trig_first_a: assert property (first_timer_reset |-> !(&unit_uses_alt[4:3]))
    else $error("unused first timer reset");
  trig_third_a: assert property (third_timer_reset |-> (|unit_uses_alt[4:3]))
    else $error("unused third timer reset");
  bad_addr_a: assert property (psel && !penable && paddr > `CCPM_A_U5_HIGH |=> pslverr)
    else $error("unmapped not refused");
  good_addr_a: assert property (psel && !penable && paddr == `CCPM_A_LIMIT |=> !pslverr)
    else $error("mapped access refused");
endmodule // ccpm_props
bind ccpm_top ccpm_props u_props (.*);

// ---- tb/ccpm_top_test.sv ----
// Self-checking bench for the mode select block
`include "ccpm_regs.vh"
module ccpm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;     // Bus request
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] t1 = 16'h0;      // Outside capture/compare timers
  logic [15:0] t3 = 16'h0;
  logic [7:0]  t2 = 8'h00;      // Outside PWM timer
  logic        t2r = 1'b0;
  logic [1:0]  latch = 2'b11;   // Port latches
  logic [1:0]  ev = 2'b00;      // Outside pin driver
  logic [1:0]  een = 2'b01;
  logic [31:0] rd_q;            // Last read data
  logic        err_q;
  wire  [31:0] prdata;
  wire         pready, pslverr, t1rst, t3rst, adc, base;
  wire  [4:0]  alt;
  wire  [1:0]  pin, pout, poe_n;
  int          n_fail = 0, n_checks = 0, nt1, nt3, nad, c;
  logic [7:0]  ra [9] = '{`CCPM_A_COUNT, `CCPM_A_LIMIT, `CCPM_A_CTRL, `CCPM_A_U4_CTRL,
    `CCPM_A_U4_LOW, `CCPM_A_U4_HIGH, `CCPM_A_U5_CTRL, `CCPM_A_U5_LOW, `CCPM_A_U5_HIGH};
  logic [7:0]  rv [9] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  wv [9] = '{8'ha5, 8'h5a, 8'h7b, 8'h30, 8'ha5, 8'h5a, 8'h20, 8'hc3, 8'h3c};
  logic [4:0]  rt [4] = '{5'h00, 5'h1e, 5'h1c, 5'h1f};
  logic [3:0]  md [5] = '{`CCPM_M_TOGGLE, `CCPM_M_CMP_HI, `CCPM_M_CMP_LO, `CCPM_M_CMP_SW,
    `CCPM_M_CMP_TRIG};
  logic        pre [3] = '{1'b0, 1'b0, 1'b1};
  int          cn [4] = '{1, 1, 4, 16};
  ccpm_top u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .first_timer_count(t1), .third_timer_count(t3), .second_timer_count(t2),
    .second_timer_restart(t2r), .first_timer_reset(t1rst), .third_timer_reset(t3rst),
    .adc_start(adc), .period_timer_base(base), .unit_uses_alt(alt), .unit_pin_in(pin),
    .unit_port_latch(latch), .unit_pin_out(pout), .unit_pin_oe_n(poe_n));
  ccpm_pin_model u_pins (.pin_out(pout), .pin_oe_n(poe_n), .ext_val(ev), .ext_en(een),
    .pin_lvl(pin));
  // Free-running clock
  always #5 pclk = ~pclk;
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A wait that ran out ends the run
  task tmo(input int k);
    if (k >= 300)
    begin
      n_fail++;
      $display("BAD wait expected done seen timeout");
      finish_test();
    end
  endtask
  // One bus transfer: setup, then access until ready
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 300);
    tmo(k);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdck(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    ck($sformatf("reg %h", a), e, rd_q);
  endtask
  task pinck(input logic o, input logic oe);
    repeat (3) @(negedge pclk);
    ck("pin", {o, oe}, {pout[0], poe_n[0]});
  endtask
  // Cycles up to the next time base pulse
  task waitb(output int n);
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (base !== 1'b1 && n < 300);
    tmo(n);
  endtask
  // Both compare timers pass the match value once
  task hit;
    nt1 = 0;
    nt3 = 0;
    nad = 0;
    @(posedge pclk);
    t1 <= 16'h0010;
    t3 <= 16'h0010;
    repeat (6)
    begin
      @(negedge pclk);
      nt1 += t1rst;
      nt3 += t3rst;
      nad += adc;
    end
    t1 <= 16'h0000;
    t3 <= 16'h0000;
    repeat (2) @(posedge pclk);
  endtask
  // One rising then one falling edge from outside
  task wiggle;
    @(posedge pclk);
    ev <= 2'b01;
    repeat (3) @(posedge pclk);
    ev <= 2'b00;
    repeat (3) @(posedge pclk);
  endtask
  task restart;
    @(posedge pclk);
    t2r <= 1'b1;
    @(posedge pclk);
    t2r <= 1'b0;
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then pattern read-back
    foreach (ra[i])
    begin
      rdck(ra[i], rv[i]);
      xfer(1'b1, ra[i], wv[i]);
      rdck(ra[i], wv[i]);
    end
    xfer(1'b0, 8'h3c, 8'h00);
    ck("unmapped", 32'h0000_0001, err_q);
    // Period per prescale code, limit 3
    xfer(1'b1, `CCPM_A_COUNT, 8'h00);
    xfer(1'b1, `CCPM_A_LIMIT, 8'h03);
    for (int p = 0; p < 4; p++)
    begin
      xfer(1'b1, `CCPM_A_CTRL, 8'h04 | p[7:0]);
      waitb(c);
      waitb(c);
      ck("period", 4 * (p == 0 ? 1 : (p == 1 ? 4 : 16)), c);
    end
    // Stopped timer keeps its count across a control write
    xfer(1'b1, `CCPM_A_CTRL, 8'h00);
    xfer(1'b1, `CCPM_A_COUNT, 8'h05);
    xfer(1'b1, `CCPM_A_CTRL, 8'h00);
    rdck(`CCPM_A_COUNT, 8'h05);
    // Postscale 1:16 needs sixteen matches
    xfer(1'b1, `CCPM_A_LIMIT, 8'h07);
    xfer(1'b1, `CCPM_A_COUNT, 8'h00);
    xfer(1'b1, `CCPM_A_FLAGS, 8'h07);
    xfer(1'b1, `CCPM_A_CTRL, 8'h7c);
    repeat (15) waitb(c);
    rdck(`CCPM_A_FLAGS, 8'h00);
    waitb(c);
    rdck(`CCPM_A_FLAGS, 8'h01);
    xfer(1'b1, `CCPM_A_CTRL, 8'h00);
    xfer(1'b1, `CCPM_A_FLAGS, 8'h01);
    rdck(`CCPM_A_FLAGS, 8'h00);
    // Every routing code
    for (int r = 0; r < 4; r++)
    begin
      xfer(1'b1, `CCPM_A_ROUTE, r[7:0]);
      @(negedge pclk);
      ck("route", rt[r], alt);
    end
    // Compare modes on unit four, first timer, then the trigger on the third timer
    xfer(1'b1, `CCPM_A_ROUTE, 8'h00);
    xfer(1'b1, `CCPM_A_U4_LOW, 8'h10);
    xfer(1'b1, `CCPM_A_U4_HIGH, 8'h00);
    foreach (md[i])
    begin
      xfer(1'b1, `CCPM_A_FLAGS, 8'h07);
      xfer(1'b1, `CCPM_A_U4_CTRL, {4'h0, md[i]});
      if (i < 3)
        pinck(pre[i], 1'b0);
      hit();
      if (i < 3)
        pinck(~pre[i], 1'b0);
      rdck(`CCPM_A_FLAGS, 8'h02);
    end
    ck("trig", {8'h01, 8'h00, 8'h01}, {nt1[7:0], nt3[7:0], nad[7:0]});
    xfer(1'b1, `CCPM_A_ROUTE, 8'h03);
    hit();
    ck("trig", {8'h00, 8'h01, 8'h01}, {nt1[7:0], nt3[7:0], nad[7:0]});
    // Capture modes, third timer, outside edges
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, `CCPM_A_U4_CTRL, 8'h00);
      xfer(1'b1, `CCPM_A_U4_LOW, 8'h00);
      xfer(1'b1, `CCPM_A_U4_CTRL, 8'h04 + i[7:0]);
      t3 <= {8'h12, 8'hc0 + i[7:0]};
      repeat (cn[i] - 1) wiggle();
      rdck(`CCPM_A_U4_LOW, 8'h00);
      wiggle();
      rdck(`CCPM_A_U4_LOW, 8'hc0 + i[7:0]);
    end
    rdck(`CCPM_A_U4_HIGH, 8'h12);
    // Open drain through the shared address
    een <= 2'b00;
    xfer(1'b1, `CCPM_A_WDOG, 8'h10);
    xfer(1'b1, `CCPM_A_SHARED, 8'h08);
    rdck(`CCPM_A_SHARED, 8'h08);
    xfer(1'b1, `CCPM_A_U4_CTRL, {4'h0, `CCPM_M_CMP_LO});
    repeat (3) @(negedge pclk);
    ck("drain", 32'h0000_0003, {poe_n[0], pin[0]});
    xfer(1'b1, `CCPM_A_SHARED, 8'h00);
    pinck(1'b1, 1'b0);
    xfer(1'b1, `CCPM_A_WDOG, 8'h00);
    xfer(1'b1, `CCPM_A_SHARED, 8'h08);
    t1 <= 16'hab00;
    rdck(`CCPM_A_SHARED, 8'hab);
    // PWM on the second timer
    xfer(1'b1, `CCPM_A_ROUTE, 8'h00);
    xfer(1'b1, `CCPM_A_U4_LOW, 8'h00);
    xfer(1'b1, `CCPM_A_U4_CTRL, 8'h0c);
    restart();
    pinck(1'b0, 1'b0);
    xfer(1'b1, `CCPM_A_U4_LOW, 8'h80);
    restart();
    pinck(1'b1, 1'b0);
    rdck(`CCPM_A_U4_HIGH, 8'h80);
    t2 <= 8'h80;
    pinck(1'b0, 1'b0);
    finish_test();
  end
endmodule // ccpm_top_test
